// File: core/abe_exec.v
// alu, compare, skip and relative branch execution unit with apb access
// Functional notes
// - add two registers, optionally with carry; update Z C N V H; one cycle.
// - subtract registers, optionally minus carry; update Z C N V H; one cycle.
// - subtract immediate from register; update Z C N V H; one cycle.
// - subtract immediate and carry from register; update Z C N V H; one cycle.
// - and, or with register or immediate, xor with register, update only Z N V S; one cycle.
// - set-bits ors immediate mask into register, updates Z N V, one cycle.
// - clear-bits ands register with all-ones minus mask, updates Z N V.
// - test ands register with itself, keeps value, updates Z N V.
// - compare-skip-equal skips next instruction (pc plus 2 or 3); 1 or 2 cycles.
// - compares compute difference without storing; update Z N V C H.
// - skip when selected register bit is zero; 1 or 2 cycles.
// - skip when selected register bit is one; no flag changes.
// - skip when selected i/o bit is zero; 1 or 2 cycles.
`timescale 1ns/1ns
`default_nettype none
`include "abe_consts.vh"
module abe_exec (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // core state
   output reg busy,
   output reg [`ABE_PC_W-1:0] pc
);
   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   reg [7:0] gpr [0:31];
   reg [7:0] sreg;
   reg [`ABE_PC_W-1:0] stack_top;
   reg [7:0] io_val;
   reg next_two_words;
   reg [15:0] retired;
   reg [31:0] last_cmd;
   reg skip_taken;
   reg [2:0] last_cycles;
   reg bad_op;
   reg [2:0] cyc_left;
   integer i;

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function op_is_skip;
      input [4:0] op;
      begin
         op_is_skip = (op == `ABE_OP_COMPARE_SKIP_EQUAL) ||
            (op == `ABE_OP_SKIP_REG_BIT_CLEAR) ||
            (op == `ABE_OP_SKIP_REG_BIT_SET) ||
            (op == `ABE_OP_SKIP_IO_BIT_CLEAR);
      end
   endfunction

   function [2:0] op_cycles;
      input [4:0] op;
      input skip;
      begin
         case (op)
            `ABE_OP_RELATIVE_JUMP: op_cycles = `ABE_CYC_2;
            `ABE_OP_RELATIVE_SUBROUTINE: op_cycles = `ABE_CYC_3;
            `ABE_OP_SUBROUTINE_EXIT: op_cycles = `ABE_CYC_4;
            `ABE_OP_INTERRUPT_EXIT: op_cycles = `ABE_CYC_4;
            default: begin
               // a taken skip costs one extra cycle
               if (op_is_skip(op) && skip) begin
                  op_cycles = `ABE_CYC_2;
               end else begin
                  op_cycles = `ABE_CYC_1;
               end
            end
         endcase
      end
   endfunction

   function addr_is_reg;
      input [7:0] a;
      begin
         case (a)
            `ABE_ADDR_CMD, `ABE_ADDR_STATUS, `ABE_ADDR_SREG, `ABE_ADDR_PC,
            `ABE_ADDR_STACK, `ABE_ADDR_IO, `ABE_ADDR_NEXT,
            `ABE_ADDR_RETIRED: addr_is_reg = 1'b1;
            default: addr_is_reg = 1'b0;
         endcase
      end
   endfunction

   // -----------------------------------------------------------------
   // apb decode
   // -----------------------------------------------------------------
   wire access;
   wire done;
   wire wr_done;
   wire rf_hit;
   wire mapped;
   wire stalled;
   wire load_answer;
   wire issue;

   assign access = psel & penable;
   assign done = access & pready;
   assign wr_done = done & pwrite;
   assign rf_hit = paddr[`ABE_RF_SEL_BIT] & (paddr[`ABE_WORD_LSBS] == 2'b00);
   assign mapped = rf_hit | addr_is_reg(paddr);
   // writes wait while an instruction still occupies the core, so that
   // software never changes operands or pc under a multi-cycle op
   assign stalled = pwrite & busy;
   assign load_answer = access & ~pready & ~stalled;
   assign issue = wr_done & ~paddr[`ABE_RF_SEL_BIT] & (paddr == `ABE_ADDR_CMD);

   // -----------------------------------------------------------------
   // command fields and operands
   // -----------------------------------------------------------------
   wire [4:0] cmd_op;
   wire [4:0] cmd_rd;
   wire [4:0] cmd_src;
   wire [`ABE_PC_W-1:0] cmd_k;
   wire [7:0] cmd_imm;
   wire [2:0] cmd_bit;
   wire [7:0] dst_val;
   wire [7:0] src_val;
   wire op_ok;

   assign cmd_op = pwdata[`ABE_CMD_OP];
   assign cmd_rd = pwdata[`ABE_CMD_RD];
   assign cmd_src = pwdata[`ABE_CMD_SRC];
   assign cmd_k = pwdata[`ABE_CMD_K];
   assign cmd_imm = pwdata[`ABE_CMD_IMM];
   assign cmd_bit = pwdata[`ABE_CMD_BIT];
   assign dst_val = gpr[cmd_rd];
   assign src_val = gpr[cmd_src];
   assign op_ok = (cmd_op <= `ABE_OP_LAST);

   wire [7:0] alu_result;
   wire [7:0] alu_flags;
   wire [7:0] alu_mask;
   wire alu_write;

   abe_alu u_alu (
      .op(cmd_op),
      .dst(dst_val),
      .src(src_val),
      .imm(cmd_imm),
      .carry_in(sreg[`ABE_F_C]),
      .result(alu_result),
      .flags(alu_flags),
      .flag_mask(alu_mask),
      .write_dst(alu_write)
   );

   // -----------------------------------------------------------------
   // skip decision and next program counter
   // -----------------------------------------------------------------
   reg skip;
   reg [`ABE_PC_W-1:0] next_pc;
   reg [2:0] next_cycles;

   always @* begin
      case (cmd_op)
         `ABE_OP_COMPARE_SKIP_EQUAL: skip = (dst_val == src_val);
         `ABE_OP_SKIP_REG_BIT_CLEAR: skip = ~src_val[cmd_bit];
         `ABE_OP_SKIP_REG_BIT_SET: skip = src_val[cmd_bit];
         `ABE_OP_SKIP_IO_BIT_CLEAR: skip = ~io_val[cmd_bit];
         default: skip = 1'b0;
      endcase
   end

   always @* begin
      case (cmd_op)
         `ABE_OP_RELATIVE_JUMP, `ABE_OP_RELATIVE_SUBROUTINE: begin
            next_pc = pc + cmd_k + `ABE_PC_STEP;
         end
         `ABE_OP_SUBROUTINE_EXIT, `ABE_OP_INTERRUPT_EXIT: begin
            next_pc = stack_top;
         end
         default: begin
            // the skipped instruction may be one or two words long
            if (skip) begin
               next_pc = pc + (next_two_words ? `ABE_SKIP_TWO_WORDS : `ABE_SKIP_ONE_WORD);
            end else begin
               next_pc = pc + `ABE_PC_STEP;
            end
         end
      endcase
      next_cycles = op_cycles(cmd_op, skip);
   end

   // -----------------------------------------------------------------
   // read data
   // -----------------------------------------------------------------
   reg [31:0] next_rdata;

   always @* begin
      next_rdata = 32'h0000_0000;
      if (rf_hit) begin
         next_rdata[7:0] = gpr[paddr[`ABE_RF_IDX]];
      end else begin
         case (paddr)
            `ABE_ADDR_CMD: next_rdata = last_cmd;
            `ABE_ADDR_STATUS: begin
               next_rdata[`ABE_ST_BUSY] = busy;
               next_rdata[`ABE_ST_SKIP] = skip_taken;
               next_rdata[`ABE_ST_CYC] = last_cycles;
               next_rdata[`ABE_ST_BADOP] = bad_op;
            end
            `ABE_ADDR_SREG: next_rdata[7:0] = sreg;
            `ABE_ADDR_PC: next_rdata[`ABE_PC_W-1:0] = pc;
            `ABE_ADDR_STACK: next_rdata[`ABE_PC_W-1:0] = stack_top;
            `ABE_ADDR_IO: next_rdata[7:0] = io_val;
            `ABE_ADDR_NEXT: next_rdata[0] = next_two_words;
            `ABE_ADDR_RETIRED: next_rdata[15:0] = retired;
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // apb handshake: one wait state for reads and idle writes, answer registered
   // -----------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= load_answer;
         pslverr <= load_answer & ~mapped;
         if (load_answer && !pwrite) begin
            prdata <= next_rdata;
         end
      end
   end

   // -----------------------------------------------------------------
   // cycle occupancy
   // -----------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cyc_left <= 3'h0;
         busy <= 1'b0;
      end else if (issue && op_ok) begin
         cyc_left <= next_cycles - `ABE_CYC_1;
         busy <= (next_cycles != `ABE_CYC_1);
      end else if (cyc_left != 3'h0) begin
         cyc_left <= cyc_left - `ABE_CYC_1;
         busy <= (cyc_left != `ABE_CYC_1);
      end
   end

   // -----------------------------------------------------------------
   // architectural state: execution and software writes
   // -----------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 0; i < 32; i = i + 1) begin
            gpr[i] <= 8'h00;
         end
         sreg <= `ABE_SREG_RST;
         pc <= {`ABE_PC_W{1'b0}};
         stack_top <= {`ABE_PC_W{1'b0}};
         io_val <= 8'h00;
         next_two_words <= 1'b0;
         retired <= 16'h0000;
         last_cmd <= 32'h0000_0000;
         skip_taken <= 1'b0;
         last_cycles <= 3'h0;
         bad_op <= 1'b0;
      end else if (issue) begin
         last_cmd <= pwdata;
         if (op_ok) begin
            if (alu_write) begin
               gpr[cmd_rd] <= alu_result;
            end
            // only flags named by the op change
            sreg <= (sreg & ~alu_mask) | (alu_flags & alu_mask);
            if (cmd_op == `ABE_OP_INTERRUPT_EXIT) begin
               sreg[`ABE_F_I] <= 1'b1;
            end
            if (cmd_op == `ABE_OP_RELATIVE_SUBROUTINE) begin
               stack_top <= pc + `ABE_PC_STEP;
            end
            pc <= next_pc;
            retired <= retired + 16'h0001;
            skip_taken <= op_is_skip(cmd_op) & skip;
            last_cycles <= next_cycles;
         end else begin
            // unknown codes change nothing but last_cmd, and are flagged to software
            bad_op <= 1'b1;
         end
      end else if (wr_done) begin
         if (rf_hit) begin
            gpr[paddr[`ABE_RF_IDX]] <= pwdata[7:0];
         end else begin
            case (paddr)
               `ABE_ADDR_STATUS: begin
                  if (pwdata[`ABE_ST_BADOP]) begin
                     bad_op <= 1'b0;
                  end
               end
               `ABE_ADDR_SREG: sreg <= pwdata[7:0];
               `ABE_ADDR_PC: pc <= pwdata[`ABE_PC_W-1:0];
               `ABE_ADDR_STACK: stack_top <= pwdata[`ABE_PC_W-1:0];
               `ABE_ADDR_IO: io_val <= pwdata[7:0];
               `ABE_ADDR_NEXT: next_two_words <= pwdata[0];
               default: begin
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// File: core/abe_consts.vh
// constants for the alu and branch execute block
`ifndef ABE_CONSTS_VH
`define ABE_CONSTS_VH
// -----------------------------------------------------------------
// apb register offsets (byte addresses)
// -----------------------------------------------------------------
`define ABE_ADDR_CMD 8'h00
`define ABE_ADDR_STATUS 8'h04
`define ABE_ADDR_SREG 8'h08
`define ABE_ADDR_PC 8'h0c
`define ABE_ADDR_STACK 8'h10
`define ABE_ADDR_IO 8'h14
`define ABE_ADDR_NEXT 8'h18
`define ABE_ADDR_RETIRED 8'h1c
`define ABE_RF_SEL_BIT 7
`define ABE_RF_IDX 6:2
`define ABE_WORD_LSBS 1:0
// -----------------------------------------------------------------
// command word fields
// -----------------------------------------------------------------
`define ABE_CMD_OP 4:0
`define ABE_CMD_RD 9:5
`define ABE_CMD_SRC 14:10
`define ABE_CMD_K 26:15
`define ABE_CMD_IMM 22:15
`define ABE_CMD_BIT 17:15
`define ABE_PC_W 12
// -----------------------------------------------------------------
// status register bits, masks and reset
// -----------------------------------------------------------------
`define ABE_F_C 0
`define ABE_F_Z 1
`define ABE_F_N 2
`define ABE_F_V 3
`define ABE_F_S 4
`define ABE_F_H 5
`define ABE_F_I 7
`define ABE_SREG_RST 8'h00
`define ABE_MASK_ARITH 8'h3f
`define ABE_MASK_LOGIC 8'h1e
`define ABE_MASK_ONES 8'h1f
`define ABE_MASK_NONE 8'h00
// status word bits
`define ABE_ST_BUSY 0
`define ABE_ST_SKIP 1
`define ABE_ST_CYC 4:2
`define ABE_ST_BADOP 5
// -----------------------------------------------------------------
// operation codes
// -----------------------------------------------------------------
`define ABE_OP_ADD 5'h00
`define ABE_OP_ADD_CARRY 5'h01
`define ABE_OP_SUB 5'h02
`define ABE_OP_DIFFERENCE_IMMEDIATE 5'h03
`define ABE_OP_DIFFERENCE_WITH_BORROW 5'h04
`define ABE_OP_DIFFERENCE_IMM_BORROW 5'h05
`define ABE_OP_AND 5'h06
`define ABE_OP_BITWISE_CONJ_IMM 5'h07
`define ABE_OP_OR 5'h08
`define ABE_OP_BITWISE_DISJ_IMM 5'h09
`define ABE_OP_BITWISE_XOR_REGS 5'h0a
`define ABE_OP_ONES_INVERT 5'h0b
`define ABE_OP_TWOS_INVERT 5'h0c
`define ABE_OP_SET_MASK_BITS 5'h0d
`define ABE_OP_CLEAR_MASK_BITS 5'h0e
`define ABE_OP_PLUS_ONE 5'h0f
`define ABE_OP_MINUS_ONE 5'h10
`define ABE_OP_TEST_VALUE 5'h11
`define ABE_OP_ZERO_REG 5'h12
`define ABE_OP_ALL_ONES_REG 5'h13
`define ABE_OP_RELATIVE_JUMP 5'h14
`define ABE_OP_RELATIVE_SUBROUTINE 5'h15
`define ABE_OP_SUBROUTINE_EXIT 5'h16
`define ABE_OP_INTERRUPT_EXIT 5'h17
`define ABE_OP_COMPARE_SKIP_EQUAL 5'h18
`define ABE_OP_COMPARE_REGS 5'h19
`define ABE_OP_COMPARE_REGS_BORROW 5'h1a
`define ABE_OP_COMPARE_IMMEDIATE 5'h1b
`define ABE_OP_SKIP_REG_BIT_CLEAR 5'h1c
`define ABE_OP_SKIP_REG_BIT_SET 5'h1d
`define ABE_OP_SKIP_IO_BIT_CLEAR 5'h1e
`define ABE_OP_LAST 5'h1e
// -----------------------------------------------------------------
// cycle counts and program counter steps
// -----------------------------------------------------------------
`define ABE_CYC_1 3'h1
`define ABE_CYC_2 3'h2
`define ABE_CYC_3 3'h3
`define ABE_CYC_4 3'h4
`define ABE_PC_STEP 12'h001
`define ABE_SKIP_ONE_WORD 12'h002
`define ABE_SKIP_TWO_WORDS 12'h003
`define ABE_ALL_ONES 8'hff
`endif

// File: core/abe_alu.v
// arithmetic and logic unit with status flag generation
`timescale 1ns/1ns
`default_nettype none
`include "abe_consts.vh"
module abe_alu (
   // operation
   input wire [4:0] op,
   // operands
   input wire [7:0] dst,
   input wire [7:0] src,
   input wire [7:0] imm,
   input wire carry_in,
   // results
   output reg [7:0] result,
   output reg [7:0] flags,
   output reg [7:0] flag_mask,
   output reg write_dst
);
   reg [7:0] x;
   reg [7:0] y;
   reg cy;
   reg is_sub;
   reg is_logic;
   reg force_carry;
   reg [7:0] lres;
   reg [8:0] wide;
   reg [4:0] nib;
   reg ovf;

   always @* begin
      x = dst;
      y = src;
      cy = 1'b0;
      is_sub = 1'b0;
      is_logic = 1'b0;
      force_carry = 1'b0;
      lres = dst & src;
      write_dst = 1'b1;
      flag_mask = `ABE_MASK_ARITH;
      case (op)
         `ABE_OP_ADD: begin
         end
         `ABE_OP_ADD_CARRY: cy = carry_in;
         `ABE_OP_SUB: is_sub = 1'b1;
         `ABE_OP_DIFFERENCE_WITH_BORROW: begin
            is_sub = 1'b1;
            cy = carry_in;
         end
         `ABE_OP_DIFFERENCE_IMMEDIATE: begin
            is_sub = 1'b1;
            y = imm;
         end
         `ABE_OP_DIFFERENCE_IMM_BORROW: begin
            is_sub = 1'b1;
            y = imm;
            cy = carry_in;
         end
         `ABE_OP_COMPARE_REGS, `ABE_OP_COMPARE_REGS_BORROW, `ABE_OP_COMPARE_IMMEDIATE: begin
            // difference only, destination kept
            is_sub = 1'b1;
            write_dst = 1'b0;
            if (op == `ABE_OP_COMPARE_IMMEDIATE) begin
               y = imm;
            end
            if (op == `ABE_OP_COMPARE_REGS_BORROW) begin
               cy = carry_in;
            end
         end
         `ABE_OP_TWOS_INVERT: begin
            is_sub = 1'b1;
            x = 8'h00;
            y = dst;
         end
         `ABE_OP_PLUS_ONE, `ABE_OP_MINUS_ONE: begin
            is_sub = (op == `ABE_OP_MINUS_ONE);
            y = 8'h01;
            flag_mask = `ABE_MASK_LOGIC;
         end
         `ABE_OP_AND, `ABE_OP_OR, `ABE_OP_BITWISE_XOR_REGS, `ABE_OP_BITWISE_CONJ_IMM,
         `ABE_OP_BITWISE_DISJ_IMM: begin
            is_logic = 1'b1;
            flag_mask = `ABE_MASK_LOGIC;
            if (op == `ABE_OP_OR) begin
               lres = dst | src;
            end else if (op == `ABE_OP_BITWISE_XOR_REGS) begin
               lres = dst ^ src;
            end else if (op == `ABE_OP_BITWISE_CONJ_IMM) begin
               lres = dst & imm;
            end else if (op == `ABE_OP_BITWISE_DISJ_IMM) begin
               lres = dst | imm;
            end
         end
         `ABE_OP_SET_MASK_BITS: begin
            is_logic = 1'b1;
            flag_mask = `ABE_MASK_LOGIC;
            lres = dst | imm;
         end
         `ABE_OP_CLEAR_MASK_BITS: begin
            is_logic = 1'b1;
            flag_mask = `ABE_MASK_LOGIC;
            lres = dst & (`ABE_ALL_ONES - imm);
         end
         `ABE_OP_TEST_VALUE: begin
            is_logic = 1'b1;
            flag_mask = `ABE_MASK_LOGIC;
            lres = dst & dst;
            write_dst = 1'b0;
         end
         `ABE_OP_ZERO_REG: begin
            is_logic = 1'b1;
            flag_mask = `ABE_MASK_LOGIC;
            lres = dst ^ dst;
         end
         `ABE_OP_ONES_INVERT: begin
            is_logic = 1'b1;
            force_carry = 1'b1;
            flag_mask = `ABE_MASK_ONES;
            lres = `ABE_ALL_ONES - dst;
         end
         `ABE_OP_ALL_ONES_REG: begin
            is_logic = 1'b1;
            flag_mask = `ABE_MASK_NONE;
            lres = `ABE_ALL_ONES;
         end
         default: begin
            // branches and skips touch neither registers nor flags
            write_dst = 1'b0;
            flag_mask = `ABE_MASK_NONE;
         end
      endcase
      if (is_sub) begin
         wide = {1'b0, x} - {1'b0, y} - {8'h00, cy};
         nib = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, cy};
         ovf = (x[7] != y[7]) && (wide[7] != x[7]);
      end else begin
         wide = {1'b0, x} + {1'b0, y} + {8'h00, cy};
         nib = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cy};
         ovf = (x[7] == y[7]) && (wide[7] != x[7]);
      end
      result = is_logic ? lres : wide[7:0];
      flags = 8'h00;
      flags[`ABE_F_C] = is_logic ? force_carry : wide[8];
      flags[`ABE_F_H] = nib[4];
      flags[`ABE_F_V] = is_logic ? 1'b0 : ovf;
      flags[`ABE_F_N] = result[7];
      flags[`ABE_F_Z] = (result == 8'h00);
      flags[`ABE_F_S] = flags[`ABE_F_N] ^ flags[`ABE_F_V];
   end
endmodule
`default_nettype wire

// File: testbench/abe_exec_checker.sv
// checker: apb handshake and instruction timing of the execute block
`timescale 1ns/1ns
`default_nettype none
`include "abe_consts.vh"
module abe_exec_checker (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // core state
   input wire logic busy,
   input wire logic [11:0] pc
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic done_cmd;
   logic [4:0] op;
   // command accepted at the edge where the write completes
   assign done_cmd = psel && penable && pready && pwrite && (paddr == `ABE_ADDR_CMD);
   assign op = pwdata[`ABE_CMD_OP];
   // ---------------------------------------------------------------
   // handshake
   // ---------------------------------------------------------------
   property p_err_ready; pslverr |-> pready; endproperty
   a_err_ready: assert property (p_err_ready) else $error("error flag without ready");
   property p_ready_pulse; pready |=> !pready; endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready held over one cycle");
   property p_read_wait; psel && !penable && !pwrite |-> ##2 pready; endproperty
   a_read_wait: assert property (p_read_wait) else $error("read not answered after one wait");
   property p_write_free; psel && !penable && pwrite && !busy |-> ##2 pready; endproperty
   a_write_free: assert property (p_write_free) else $error("idle write not answered in time");
   property p_write_stall; psel && penable && pwrite && busy && !pready |=> !pready; endproperty
   a_write_stall: assert property (p_write_stall) else $error("write answered while busy");
   // ---------------------------------------------------------------
   // instruction timing
   // ---------------------------------------------------------------
   property p_alu_one; done_cmd && op < `ABE_OP_RELATIVE_JUMP |=> !busy; endproperty
   a_alu_one: assert property (p_alu_one) else $error("alu op took extra cycles");
   property p_skip_max; done_cmd && op >= `ABE_OP_COMPARE_SKIP_EQUAL |=> ##1 !busy; endproperty
   a_skip_max: assert property (p_skip_max) else $error("skip took over two cycles");
   property p_jump; done_cmd && op == `ABE_OP_RELATIVE_JUMP |=> busy ##1 !busy; endproperty
   a_jump: assert property (p_jump) else $error("jump not two cycles");
   property p_call; done_cmd && op == `ABE_OP_RELATIVE_SUBROUTINE |=> busy[*2] ##1 !busy;
   endproperty
   a_call: assert property (p_call) else $error("call not three cycles");
   property p_ret;
      done_cmd && (op == `ABE_OP_SUBROUTINE_EXIT || op == `ABE_OP_INTERRUPT_EXIT)
         |=> busy[*3] ##1 !busy;
   endproperty
   a_ret: assert property (p_ret) else $error("return not four cycles");
   property p_pc_hold; !(psel && penable && pready && pwrite) |=> $stable(pc); endproperty
   a_pc_hold: assert property (p_pc_hold) else $error("pc moved without a write");
endmodule
bind abe_exec abe_exec_checker abe_exec_checker_inst (.clk(clk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .busy(busy), .pc(pc));
`default_nettype wire

// File: testbench/abe_exec_tb.sv
// self-checking bench for the alu and branch execute block
`timescale 1ns/1ns
`default_nettype none
module abe_exec_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rdat;
   logic pready, pslverr, busy, rerr;
   logic [11:0] pc;
   int bad_count = 0;
   int n_checks = 0;
   int cycles = 0;
   // op, then a b imm sreg_in result sreg_out, then pc step
   logic [54:0] rows [0:29] = '{
      {5'h00,48'h0f0100001020,2'd1}, {5'h01,48'hff0000010023,2'd1},
      {5'h02,48'h800100007f38,2'd1}, {5'h03,48'h10002000f015,2'd1},
      {5'h04,48'h05050001ff35,2'd1}, {5'h05,48'h010000010002,2'd1},
      {5'h06,48'hf03c00213021,2'd1}, {5'h07,48'h0f00f0080002,2'd1},
      {5'h08,48'h800100008114,2'd1}, {5'h09,48'h000000000002,2'd1},
      {5'h0a,48'haaaa00010003,2'd1}, {5'h0b,48'h00000020ff35,2'd1},
      {5'h0c,48'h01000000ff35,2'd1}, {5'h0d,48'h010080008114,2'd1},
      {5'h0e,48'hff000f00f014,2'd1}, {5'h0f,48'h7f000000800c,2'd1},
      {5'h10,48'h800000007f18,2'd1}, {5'h11,48'h000000080002,2'd1},
      {5'h12,48'h550000000002,2'd1}, {5'h13,48'h0000002bff2b,2'd1},
      {5'h18,48'h333300003300,2'd2}, {5'h18,48'h333400003300,2'd1},
      {5'h19,48'h101000001002,2'd1}, {5'h1a,48'h101000011035,2'd1},
      {5'h1b,48'h7f0080007f0d,2'd1}, {5'h1c,48'h00f703000000,2'd2},
      {5'h1d,48'h00f7033f003f,2'd1}, {5'h1d,48'h000803000000,2'd2},
      {5'h1e,48'h008007000000,2'd1}, {5'h1e,48'h008000000000,2'd2}};
   abe_exec abe_exec_inst (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .busy(busy), .pc(pc));
   always #20 clk = ~clk;
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // a hung handshake must not stall the run forever
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         bad_count++;
         finish_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // request held until ready is seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // only the bench timeout ends a wait that never sees ready
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask
   // operands in r1 and r2, io mirrors r2, command with rd 1 and source 2
   task automatic exec(input logic [54:0] r);
      apb(1'b1, 8'h84, {24'h0, r[49:42]});
      apb(1'b1, 8'h88, {24'h0, r[41:34]});
      apb(1'b1, 8'h14, {24'h0, r[41:34]});
      apb(1'b1, 8'h08, {24'h0, r[25:18]});
      apb(1'b1, 8'h0c, 32'h100);
      apb(1'b1, 8'h00, {9'h0, r[33:26], 5'd2, 5'd1, r[54:50]});
   endtask
   // ---------------------------------------------------------------
   // sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rdc(8'h08, 32'h0);
      rdc(8'h0c, 32'h0);
      rdc(8'hfc, 32'h0);
      for (int i = 0; i < 30; i++) begin
         exec(rows[i]);
         rdc(8'h84, {24'h0, rows[i][17:10]});
         rdc(8'h08, {24'h0, rows[i][9:2]});
         chk({20'h0, pc}, 32'h100 + rows[i][1:0]);
      end
      // two-word follower makes a taken skip step by three
      apb(1'b1, 8'h18, 32'h1);
      exec(rows[20]);
      chk({20'h0, pc}, 32'h103);
      apb(1'b1, 8'h18, 32'h0);
      // jump back by one, call forward, then both returns
      apb(1'b1, 8'h0c, 32'h100);
      apb(1'b1, 8'h00, 32'h07ff0014);
      chk({20'h0, pc}, 32'h0ff);
      rdc(8'h04, 32'h08);
      apb(1'b1, 8'h00, 32'h00080015);
      chk({20'h0, pc}, 32'h110);
      rdc(8'h10, 32'h100);
      apb(1'b1, 8'h00, 32'h00000017);
      chk({20'h0, pc}, 32'h100);
      rdc(8'h08, 32'h80);
      apb(1'b1, 8'h0c, 32'h0);
      apb(1'b1, 8'h00, 32'h00000016);
      // this write lands while the return still holds the core, so it must stall
      apb(1'b1, 8'h18, 32'h1);
      chk({20'h0, pc}, 32'h100);
      rdc(8'h18, 32'h1);
      // unmapped and misaligned places answer with an error
      apb(1'b0, 8'h81, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      chk(rdat, 32'h0);
      apb(1'b1, 8'h24, 32'h5);
      chk({31'h0, rerr}, 32'h1);
      // unknown op flag, cleared by writing one
      apb(1'b1, 8'h00, 32'h1f);
      apb(1'b0, 8'h04, 32'h0);
      chk(rdat & 32'h20, 32'h20);
      apb(1'b1, 8'h04, 32'h20);
      apb(1'b0, 8'h04, 32'h0);
      chk(rdat & 32'h20, 32'h0);
      finish_test();
   end
endmodule
`default_nettype wire
